//--- hdl/fio_pkg.sv
// Package for the forced I/O override block: point counts, command codes, timing.
// Assumes a single 125 MHz system clock and a scan-based program engine outside.
package fio_pkg;
  // Point counts per direction
  localparam int unsigned NUM_IN  = 16;
  localparam int unsigned NUM_OUT = 16;
  localparam int unsigned IDX_W   = 4;
  // Which input points act as the run-stop and reset inputs
  localparam logic [IDX_W-1:0] STOP_POINT  = 4'h0;
  localparam logic [IDX_W-1:0] RESET_POINT = 4'h1;
  // Reset values
  localparam logic [NUM_IN-1:0]  IN_RST  = 16'h0000;
  localparam logic [NUM_OUT-1:0] OUT_RST = 16'h0000;
  localparam logic [26:0]        CNT_RST = 27'h000_0000;
  // Timing
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned SLOW_PERIOD_MS  = 1000;
  localparam int unsigned FAST_PERIOD_MS  = 100;
  localparam int unsigned SLOW_HALF_CYC   = CLK_HZ / 1000 * SLOW_PERIOD_MS / 2;
  localparam int unsigned FAST_HALF_CYC   = CLK_HZ / 1000 * FAST_PERIOD_MS / 2;

  // Operator commands
  typedef enum logic [2:0] {
    FIO_OP_NOP     = 3'b000,
    FIO_OP_NEW     = 3'b001,
    FIO_OP_ON      = 3'b010,
    FIO_OP_OFF     = 3'b011,
    FIO_OP_RELEASE = 3'b100,
    FIO_OP_TOGGLE  = 3'b101,
    FIO_OP_DEL_ALL = 3'b110
  } fio_op_t;

  typedef struct packed {
    fio_op_t          op;
    logic             is_out;
    logic [IDX_W-1:0] idx;
  } fio_cmd_t;

  // Run LED modes
  typedef enum logic [1:0] {
    FIO_LED_OFF  = 2'b00,
    FIO_LED_ON   = 2'b01,
    FIO_LED_SLOW = 2'b10,
    FIO_LED_FAST = 2'b11
  } fio_led_t;

  // Whole state of the override block
  typedef struct packed {
    logic [NUM_IN-1:0]  sync1;
    logic [NUM_IN-1:0]  raw;
    logic [NUM_IN-1:0]  in_en;
    logic [NUM_IN-1:0]  in_lvl;
    logic [NUM_OUT-1:0] out_en;
    logic [NUM_OUT-1:0] out_lvl;
    logic               active;
    logic [NUM_IN-1:0]  in_img;
    logic [NUM_OUT-1:0] out_img;
    logic               rst_prev;
    fio_led_t           led_mode;
    logic [26:0]        led_cnt;
    logic               led;
  } fio_state_t;
endpackage

//--- hdl/fio_override.sv
// Forced I/O override: per-point force flags and levels, global start/suspend,
// clearing events, and the run LED pattern. Assumes the program engine gives
// one-cycle scan strobes and operator commands on the same clock.
// Operation
// - Forced input replaces terminal level for program
// - Forced output replaces program result on output
// - Every point forced independently, own flag, level
// - Forces kept across run/stop, hold when stopped
// - Power-up keeps settings, suspends forcing
// - Dead battery at power-up clears all settings
// - Download keeps settings, option selects suspend
// - Reset input, clear-all, system download clear all
// - Counter, catch, interrupt inputs see raw levels
// - Reset point turned on by forcing clears all
// - Running, not forcing: LED steadily on
// - Forcing and running: LED flashes 1 s
// - Forcing and stopped: LED flashes 100 ms
// - New command registers a point as forced
// - Force on/off commands set forced level
// - Release command returns point to normal
// - Start/suspend toggles forcing, settings kept
// - Designation stays until release or clear
`timescale 1ns/1ns
module fio_override
  #(
    parameter int unsigned SLOW_HALF = fio_pkg::SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF = fio_pkg::FAST_HALF_CYC
  )
  (
    input  wire logic                          clk_sys_in,
    input  wire logic                          rst_in,
    input  wire logic [fio_pkg::NUM_IN-1:0]    term_in,
    input  wire logic [fio_pkg::NUM_OUT-1:0]   prog_out_in,
    input  wire logic                          scan_in_latch_in,
    input  wire logic                          scan_out_update_in,
    input  wire logic                          running_in,
    input  wire logic                          maintain_outputs_when_stopped_in,
    input  wire logic                          cmd_valid_in,
    input  wire fio_pkg::fio_cmd_t             cmd_in,
    input  wire logic                          power_up_in,
    input  wire logic                          battery_fail_in,
    input  wire logic                          prog_download_in,
    input  wire logic                          download_suspend_in,
    input  wire logic                          clear_all_in,
    input  wire logic                          sys_download_in,
    output logic [fio_pkg::NUM_IN-1:0]         in_image_out,
    output logic [fio_pkg::NUM_OUT-1:0]        out_image_out,
    output logic [fio_pkg::NUM_IN-1:0]         raw_in_out,
    output logic                               stop_req_out,
    output logic                               force_active_out,
    output logic                               run_led_out
  );
  import fio_pkg::*;

  localparam logic [26:0] SLOW_LAST = 27'(SLOW_HALF - 1);
  localparam logic [26:0] FAST_LAST = 27'(FAST_HALF - 1);

  fio_state_t st_reg;
  fio_state_t st_next;

  // One-hot point select, shared by input and output decode
  function automatic logic [NUM_IN-1:0] point_mask(input logic [IDX_W-1:0] idx);
    point_mask = 16'h0001 << idx;
  endfunction

  // Forced level where designated and active, else the normal source
  function automatic logic [NUM_IN-1:0] force_mux(input logic [NUM_IN-1:0] en,
                                                  input logic [NUM_IN-1:0] lvl,
                                                  input logic [NUM_IN-1:0] norm,
                                                  input logic act);
    force_mux = act ? ((en & lvl) | (~en & norm)) : norm;
  endfunction

  logic [NUM_IN-1:0] sel_mask;
  logic              do_cmd;
  logic              rst_rise;
  logic              clear_all;
  logic              out_upd;
  logic [NUM_OUT-1:0] stop_norm;

  // Next-state logic for the whole block
  always_comb
  begin
    st_next  = st_reg;
    sel_mask = point_mask(cmd_in.idx);
    do_cmd   = cmd_valid_in;

    // Terminal levels cross into the clock domain through two flops
    st_next.sync1 = term_in;
    st_next.raw   = st_reg.sync1;

    // Operator commands; new, on, off and release touch only the selected point
    if (do_cmd)
    begin
      case (cmd_in.op)
        FIO_OP_NEW:
        begin
          if (cmd_in.is_out)
          begin
            st_next.out_en  = st_reg.out_en | sel_mask;
          end
          else
          begin
            st_next.in_en   = st_reg.in_en | sel_mask;
          end
        end
        FIO_OP_ON, FIO_OP_OFF:
        begin
          // Levels only change on registered points; unregistered ones ignore it
          if (cmd_in.is_out)
          begin
            st_next.out_lvl = (cmd_in.op == FIO_OP_ON) ? (st_reg.out_lvl | (sel_mask & st_reg.out_en))
                                                       : (st_reg.out_lvl & ~sel_mask);
          end
          else
          begin
            st_next.in_lvl  = (cmd_in.op == FIO_OP_ON) ? (st_reg.in_lvl | (sel_mask & st_reg.in_en))
                                                       : (st_reg.in_lvl & ~sel_mask);
          end
        end
        FIO_OP_RELEASE:
        begin
          if (cmd_in.is_out)
          begin
            st_next.out_en  = st_reg.out_en & ~sel_mask;
            st_next.out_lvl = st_reg.out_lvl & ~sel_mask;
          end
          else
          begin
            st_next.in_en   = st_reg.in_en & ~sel_mask;
            st_next.in_lvl  = st_reg.in_lvl & ~sel_mask;
          end
        end
        FIO_OP_TOGGLE:
        begin
          st_next.active = ~st_reg.active;
        end
        FIO_OP_DEL_ALL:
        begin
          st_next.in_en   = IN_RST;
          st_next.in_lvl  = IN_RST;
          st_next.out_en  = OUT_RST;
          st_next.out_lvl = OUT_RST;
        end
        default:
        begin
          st_next.active = st_reg.active;
        end
      endcase
    end

    // Program download keeps settings; the option decides suspension
    if (prog_download_in && download_suspend_in)
    begin
      st_next.active = 1'b0;
    end

    // Power-up suspends; settings survive unless the battery was dead
    if (power_up_in)
    begin
      st_next.active = 1'b0;
    end

    // Reset point as the program sees it, forced or physical
    rst_rise  = st_reg.in_img[RESET_POINT] & ~st_reg.rst_prev;
    st_next.rst_prev = st_reg.in_img[RESET_POINT];
    clear_all = rst_rise | clear_all_in | sys_download_in
                | (power_up_in & battery_fail_in);

    // Clearing events win over a same-cycle command
    if (clear_all)
    begin
      st_next.in_en   = IN_RST;
      st_next.in_lvl  = IN_RST;
      st_next.out_en  = OUT_RST;
      st_next.out_lvl = OUT_RST;
    end

    // Input image is latched once per scan so forcing stays consistent
    if (scan_in_latch_in)
    begin
      st_next.in_img = force_mux(st_reg.in_en, st_reg.in_lvl, st_reg.raw, st_reg.active);
    end

    // Outputs update per scan when running, every cycle when stopped
    out_upd   = scan_out_update_in | ~running_in;
    stop_norm = maintain_outputs_when_stopped_in ? st_reg.out_img : OUT_RST;
    if (out_upd)
    begin
      st_next.out_img = force_mux(st_reg.out_en, st_reg.out_lvl,
                                  running_in ? prog_out_in : stop_norm,
                                  st_reg.active);
    end

    // LED pattern chosen from run state and forcing state
    if (!running_in)
    begin
      st_next.led_mode = st_reg.active ? FIO_LED_FAST : FIO_LED_OFF;
    end
    else
    begin
      st_next.led_mode = st_reg.active ? FIO_LED_SLOW : FIO_LED_ON;
    end

    // Half-period divider; restarting on a mode change keeps 50 percent duty
    case (st_reg.led_mode)
      FIO_LED_OFF:
      begin
        st_next.led     = 1'b0;
        st_next.led_cnt = CNT_RST;
      end
      FIO_LED_ON:
      begin
        st_next.led     = 1'b1;
        st_next.led_cnt = CNT_RST;
      end
      FIO_LED_SLOW, FIO_LED_FAST:
      begin
        if (st_reg.led_cnt >= ((st_reg.led_mode == FIO_LED_SLOW) ? SLOW_LAST : FAST_LAST))
        begin
          st_next.led_cnt = CNT_RST;
          st_next.led     = ~st_reg.led;
        end
        else
        begin
          st_next.led_cnt = st_reg.led_cnt + 27'h000_0001;
        end
      end
      default:
      begin
        st_next.led_cnt = CNT_RST;
      end
    endcase
    if (st_next.led_mode != st_reg.led_mode)
    begin
      st_next.led_cnt = CNT_RST;
    end
  end

  // State register; every control bit starts cleared
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state; raw_in_out bypasses forcing, the stop request follows the input image
  assign in_image_out     = st_reg.in_img;
  assign out_image_out    = st_reg.out_img;
  assign raw_in_out       = st_reg.raw;
  assign stop_req_out     = st_reg.in_img[STOP_POINT];
  assign force_active_out = st_reg.active;
  assign run_led_out      = st_reg.led;

  // Checks next to the logic they guard
  property p_in_force;
    @(posedge clk_sys_in) disable iff (rst_in)
    scan_in_latch_in && st_reg.active |=>
      in_image_out == (($past(st_reg.in_en) & $past(st_reg.in_lvl)) | (~$past(st_reg.in_en) & $past(st_reg.raw)));
  endproperty
  a_in_force: assert property (p_in_force) else $error("forced input image wrong");

  property p_out_force;
    @(posedge clk_sys_in) disable iff (rst_in)
    scan_out_update_in && running_in && st_reg.active |=>
      out_image_out == (($past(st_reg.out_en) & $past(st_reg.out_lvl)) | (~$past(st_reg.out_en) & $past(prog_out_in)));
  endproperty
  a_out_force: assert property (p_out_force) else $error("forced output image wrong");

  property p_suspend_raw;
    @(posedge clk_sys_in) disable iff (rst_in)
    scan_in_latch_in && !st_reg.active |=> in_image_out == $past(st_reg.raw);
  endproperty
  a_suspend_raw: assert property (p_suspend_raw) else $error("suspended forcing still applied");

  property p_power_up;
    @(posedge clk_sys_in) disable iff (rst_in)
    power_up_in |=> !force_active_out;
  endproperty
  a_power_up: assert property (p_power_up) else $error("forcing active after power-up");

  property p_dead_battery;
    @(posedge clk_sys_in) disable iff (rst_in)
    power_up_in && battery_fail_in |=> st_reg.in_en == IN_RST && st_reg.out_en == OUT_RST;
  endproperty
  a_dead_battery: assert property (p_dead_battery) else $error("settings kept on dead battery");

  property p_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
    clear_all_in || sys_download_in |=> st_reg.in_en == IN_RST && st_reg.out_lvl == OUT_RST;
  endproperty
  a_clear: assert property (p_clear) else $error("clear event left settings");

  property p_reset_point;
    @(posedge clk_sys_in) disable iff (rst_in)
    $rose(in_image_out[RESET_POINT]) |=> st_reg.in_en == IN_RST && st_reg.out_en == OUT_RST;
  endproperty
  a_reset_point: assert property (p_reset_point) else $error("reset point did not clear");

  property p_led_steady;
    @(posedge clk_sys_in) disable iff (rst_in)
    (running_in && !force_active_out) [*3] |=> run_led_out;
  endproperty
  a_led_steady: assert property (p_led_steady) else $error("run LED not steady on");

  property p_toggle;
    @(posedge clk_sys_in) disable iff (rst_in)
    cmd_valid_in && cmd_in.op == FIO_OP_TOGGLE && !power_up_in && !prog_download_in
      |=> force_active_out != $past(force_active_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("start/suspend did not toggle");

  property p_duty;
    @(posedge clk_sys_in) disable iff (rst_in)
    $changed(run_led_out) && $past(st_reg.led_mode) == FIO_LED_FAST && st_reg.led_mode == FIO_LED_FAST
      |-> $past(st_reg.led_cnt) == FAST_LAST;
  endproperty
  a_duty: assert property (p_duty) else $error("fast flash half period wrong");

  // A released input must lose its designation at the very next edge
  property p_release;
    @(posedge clk_sys_in) disable iff (rst_in)
    cmd_valid_in && cmd_in.op == FIO_OP_RELEASE && !cmd_in.is_out
      |=> (st_reg.in_en & point_mask($past(cmd_in.idx))) == IN_RST;
  endproperty
  a_release: assert property (p_release) else $error("released input still designated");

  // Stopped with forcing on, designated outputs carry their forced level
  property p_stop_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
    !running_in && st_reg.active
      |=> ((out_image_out ^ $past(st_reg.out_lvl)) & $past(st_reg.out_en)) == OUT_RST;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("forced output not held while stopped");

  c_toggle:    cover property (@(posedge clk_sys_in) cmd_valid_in && cmd_in.op == FIO_OP_TOGGLE);
  c_force_on:  cover property (@(posedge clk_sys_in) cmd_valid_in && cmd_in.op == FIO_OP_ON && st_reg.active);
  c_rst_clear: cover property (@(posedge clk_sys_in) rst_rise && st_reg.in_en != IN_RST);
  c_fast:      cover property (@(posedge clk_sys_in) st_reg.led_mode == FIO_LED_FAST && $changed(run_led_out));
  c_stop_hold: cover property (@(posedge clk_sys_in) !running_in && st_reg.active && st_reg.out_en != OUT_RST);
endmodule

//--- verification/fio_field.sv
// Field side model: sensors wired to the input terminals of the override block.
// Assumes the bench sets the wanted sensor levels just after a rising clock edge.
`timescale 1ns/1ns
module fio_field
  #(
    parameter int unsigned SETTLE = 2
  )
  (
    input  wire logic                       clk_sys_in,
    input  wire logic [fio_pkg::NUM_IN-1:0] sensor_in,
    output logic      [fio_pkg::NUM_IN-1:0] term_out
  );
  import fio_pkg::*;
  logic [NUM_IN-1:0] level    = '0;
  logic [NUM_IN-1:0] pend     = '0;
  int unsigned       wait_cnt = 0;

  // Terminals show the settled contact level; one driver only
  assign term_out = level;

  // Contacts follow a change only SETTLE+1 cycles after it is seen, so the block never sees an instant switch
  always @(posedge clk_sys_in)
  begin
    if (sensor_in !== pend)
    begin
      pend     <= sensor_in;
      wait_cnt <= SETTLE;
    end
    else if (wait_cnt > 0)
      wait_cnt <= wait_cnt - 1;
    else
      level <= pend;
  end
endmodule

//--- verification/fio_override_test.sv
// Self-checking bench for the forced I/O override block, with random commands and corner cases.
// Assumes the field model drives the terminals; expected images come from the model kept here.
`timescale 1ns/1ns
module fio_override_test;
  import fio_pkg::*;
  localparam int unsigned SLOW = 10;
  localparam int unsigned FAST = 4;
  logic              clk_sys_in = 1'b0;
  logic              rst_in     = 1'b1;
  logic              lat, upd, run, maint, cvalid, pwr, batt, dl, dsus, clr, sysdl;
  logic              stop_req, act, led, o, m_act, m_known;
  logic [NUM_IN-1:0] sensor, term, in_img, raw, m_in_en, m_in_lvl, e_in;
  logic [NUM_IN-1:0] prog, out_img, m_out_en, m_out_lvl, e_out;
  logic [IDX_W-1:0]  idx;
  fio_cmd_t          cmd;
  fio_op_t           op_v;
  int                n_mismatch = 0;
  int                checks_done = 0;
  int                seed = 27;
  int                k, i;

  always #4 clk_sys_in = ~clk_sys_in;

  fio_field #(.SETTLE(2)) field (.clk_sys_in(clk_sys_in), .sensor_in(sensor), .term_out(term));

  fio_override #(.SLOW_HALF(SLOW), .FAST_HALF(FAST)) uut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .term_in(term), .prog_out_in(prog),
    .scan_in_latch_in(lat), .scan_out_update_in(upd), .running_in(run),
    .maintain_outputs_when_stopped_in(maint), .cmd_valid_in(cvalid), .cmd_in(cmd),
    .power_up_in(pwr), .battery_fail_in(batt), .prog_download_in(dl), .download_suspend_in(dsus),
    .clear_all_in(clr), .sys_download_in(sysdl), .in_image_out(in_img), .out_image_out(out_img),
    .raw_in_out(raw), .stop_req_out(stop_req), .force_active_out(act), .run_led_out(led));

  // All stimulus moves 1 ns after the edge so the design samples settled values
  task automatic tick();
    @(posedge clk_sys_in);
    #1;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic quiet();
    {lat, upd, cvalid, pwr, dl, clr, sysdl} = '0;
  endtask

  task automatic m_clear();
    {m_in_en, m_in_lvl, m_out_en, m_out_lvl} = '0;
  endtask

  task automatic do_reset();
    quiet();
    rst_in = 1'b1;
    repeat (12) tick();
    rst_in = 1'b0;
    m_clear();
    {m_act, e_in, e_out} = '0;
    m_known = 1'b1;
    tick();
  endtask

  // Valid stays high between back-to-back commands; the next quiet lowers it
  task automatic send(input fio_op_t op, input logic oo, input logic [IDX_W-1:0] ix);
    cmd    = '{op: op, is_out: oo, idx: ix};
    cvalid = 1'b1;
    tick();
    case (op)
      FIO_OP_NEW: if (oo) m_out_en[ix] = 1'b1; else m_in_en[ix] = 1'b1;
      FIO_OP_ON, FIO_OP_OFF:
        if (oo && m_out_en[ix]) m_out_lvl[ix] = (op == FIO_OP_ON);
        else if (!oo && m_in_en[ix]) m_in_lvl[ix] = (op == FIO_OP_ON);
      FIO_OP_RELEASE: if (oo) {m_out_en[ix], m_out_lvl[ix]} = 2'b00; else {m_in_en[ix], m_in_lvl[ix]} = 2'b00;
      FIO_OP_TOGGLE: m_act = ~m_act;
      FIO_OP_DEL_ALL: m_clear();
      default: ;
    endcase
  endtask

  // One program scan: terminals settle, input image must not move before the strobe
  task automatic scan(input logic [15:0] t, input logic [15:0] p);
    quiet();
    sensor = t;
    prog   = p;
    repeat (8) tick();
    chk("raw terminals", raw, t);
    chk("input image held", in_img, e_in);
    e_in  = m_act ? ((m_in_en & m_in_lvl) | (~m_in_en & t)) : t;
    e_out = run ? p : (maint ? e_out : '0);
    if (m_act) e_out = (m_out_en & m_out_lvl) | (~m_out_en & e_out);
    {lat, upd} = 2'b11;
    tick();
    {lat, upd} = 2'b00;
    repeat (2) tick();
    chk("input image", in_img, e_in);
    chk("output image", out_img, e_out);
    chk("stop request", {15'h0, stop_req}, {15'h0, e_in[STOP_POINT]});
    if (m_known) chk("force active", {15'h0, act}, {15'h0, m_act});
  endtask

  task automatic setup();
    do_reset();
    send(FIO_OP_NEW, 1'b0, STOP_POINT);
    send(FIO_OP_ON, 1'b0, STOP_POINT);
    send(FIO_OP_NEW, 1'b1, 4'h3);
    send(FIO_OP_ON, 1'b1, 4'h3);
    send(FIO_OP_TOGGLE, 1'b0, 4'h0);
    quiet();
    tick();
  endtask

  // Steady modes count wrong levels; flashing modes measure one half period
  task automatic led_chk(input logic r, input int unsigned half);
    int unsigned n;
    logic        l0;
    quiet();
    run = r;
    repeat (3 * SLOW) tick();
    n  = 0;
    l0 = led;
    if (half == 0)
    begin
      repeat (2 * SLOW) begin tick(); if (led !== r) n++; end
      chk("led steady", 16'(n), 16'h0000);
    end
    else
    begin
      while (led === l0 && n < 3 * SLOW) begin tick(); n++; end
      l0 = led;
      n  = 0;
      while (led === l0 && n < 3 * SLOW) begin tick(); n++; end
      chk("led half period", 16'(n), 16'(half));
    end
  endtask

  initial
  begin
    {run, maint, batt, dsus} = '0;
    sensor = '0;
    prog   = '0;
    cmd    = '0;
    do_reset();
    chk("reset images", in_img | out_img | raw, 16'h0000);
    chk("reset flags", {13'h0, act, led, stop_req}, 16'h0000);
    // Random commands, refused ones among them; bit 1 stays low so the reset point never fires
    run = 1'b1;
    for (i = 0; i < 40; i++)
    begin
      k    = $unsigned($random(seed)) % 5;
      o    = 1'($random(seed));
      idx  = IDX_W'($random(seed));
      op_v = $random(seed) & 1 ? FIO_OP_ON : FIO_OP_OFF;
      if (!o && idx == RESET_POINT) op_v = FIO_OP_OFF;
      case (k)
        0: begin send(FIO_OP_NEW, o, idx); send(op_v, o, idx); end
        1: send(FIO_OP_RELEASE, o, idx);
        2: send(FIO_OP_TOGGLE, o, idx);
        3: send(op_v, o, idx);
        default: send(FIO_OP_NOP, o, idx);
      endcase
      scan(16'($random(seed)) & 16'hFFFD, 16'($random(seed)));
    end
    $display("test random commands done");
    // Power-up, download and clearing events on an active set of forces
    for (k = 0; k < 6; k++)
    begin
      setup();
      case (k)
        0: begin pwr = 1'b1; batt = 1'b0; m_act = 1'b0; end
        1: begin pwr = 1'b1; batt = 1'b1; m_clear(); m_act = 1'b0; end
        2: begin dl = 1'b1; dsus = 1'b1; m_act = 1'b0; end
        3: begin dl = 1'b1; dsus = 1'b0; end
        4: begin clr = 1'b1; m_clear(); m_known = 1'b0; end
        default: begin sysdl = 1'b1; m_clear(); m_known = 1'b0; end
      endcase
      tick();
      scan(16'h0000, 16'h0000);
      if (k == 0 || k == 2)
      begin
        send(FIO_OP_TOGGLE, 1'b0, 4'h0);
        scan(16'h0000, 16'h0000);
      end
    end
    $display("test events done");
    // Stopped: forced points hold, others follow the maintain setting
    setup();
    scan(16'h0000, 16'h00F0);
    {run, maint} = 2'b01;
    scan(16'h0000, 16'h0F00);
    maint = 1'b0;
    scan(16'h0000, 16'h0F00);
    run = 1'b1;
    send(FIO_OP_TOGGLE, 1'b0, 4'h0);
    scan(16'h0000, 16'h0F00);
    $display("test stopped outputs done");
    // Reset point forced on clears every setting right after it shows
    do_reset();
    send(FIO_OP_NEW, 1'b0, RESET_POINT);
    send(FIO_OP_ON, 1'b0, RESET_POINT);
    send(FIO_OP_TOGGLE, 1'b0, 4'h0);
    scan(16'h0000, 16'h0000);
    m_clear();
    m_known = 1'b0;
    scan(16'h0000, 16'h0000);
    $display("test reset point done");
    // Run LED in all four modes
    setup();
    led_chk(1'b1, SLOW);
    led_chk(1'b0, FAST);
    send(FIO_OP_TOGGLE, 1'b0, 4'h0);
    led_chk(1'b1, 0);
    led_chk(1'b0, 0);
    $display("test run led done");
    // Delete-all at the end of testing releases every point
    run = 1'b1;
    setup();
    send(FIO_OP_DEL_ALL, 1'b0, 4'h0);
    scan(16'h0000, 16'h0000);
    $display("test delete all done");
    wrap_up();
  end

  // Whole run takes about a thousand cycles; 30000 cycles means a hang
  initial
  begin
    #(8 * 30000);
    n_mismatch++;
    wrap_up();
  end
endmodule
